//--- hdl/gpar_pkg.sv
// Constants for the global parameter bank and interrupt configuration bank.
// Summary of operation
// - Protection codes: none, readout, overwrite, both.
// - Dropping readout protection erases stored program.
// - Coordinate storage 1 mirrors coordinates to nonvolatile.
// - Restore user variables at startup unless inhibited.
// - Secondary address zero disables its recognition.
// - Direction invert applies in internal mode only.
// - Program position is read-only executing address.
// - 32-bit counter increments once per millisecond.
// - Writing counter loads new start value.
// - Random read returns pseudo-random; write seeds.
// - Reply suppress blocks replies to direct commands.
// - Reply suppress never stored, zero at startup.
// - Read commands always answered despite suppression.
// - 256 user variables, first 56 persistent.
// - Lower interrupt number wins when several pend.
// - Timers fire every programmed period milliseconds.
// - Two-bit edge select: off, rise, fall, both.
package gpar_pkg;
  // Bank numbers.
  localparam logic [7:0] BANK_GLOBAL = 8'h00;
  localparam logic [7:0] BANK_USER   = 8'h02;
  localparam logic [7:0] BANK_IRQ    = 8'h03;
  // Bank 0 setting numbers.
  localparam logic [7:0] GP_PROTECT  = 8'h51;
  localparam logic [7:0] GP_COORD    = 8'h54;
  localparam logic [7:0] GP_NORESTOR = 8'h55;
  localparam logic [7:0] GP_ADDR2    = 8'h57;
  localparam logic [7:0] GP_DIRINV   = 8'h5a;
  localparam logic [7:0] GP_RUNSTATE = 8'h80;
  localparam logic [7:0] GP_LOADMODE = 8'h81;
  localparam logic [7:0] GP_PROGPOS  = 8'h82;
  localparam logic [7:0] GP_TICKS    = 8'h84;
  localparam logic [7:0] GP_RANDOM   = 8'h85;
  localparam logic [7:0] GP_NOREPLY  = 8'hff;
  // Bank 3 setting numbers.
  localparam logic [7:0] IP_TIMER0   = 8'h00;
  localparam logic [7:0] IP_TIMER2   = 8'h02;
  localparam logic [7:0] IP_STOPL    = 8'h1b;
  localparam logic [7:0] IP_STOPR    = 8'h1c;
  localparam logic [7:0] IP_IN0      = 8'h27;
  localparam logic [7:0] IP_IN3      = 8'h2a;
  // Protection code bit positions.
  localparam int PROT_READ_BIT  = 0;
  localparam int PROT_WRITE_BIT = 1;
  // Edge select codes.
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Bank sizes and persistent user variable count.
  localparam int USER_VARS    = 256;
  localparam int USER_PERSIST = 56;
  localparam int NUM_IRQ      = 9;
  // Random generator reset seed.
  localparam logic [31:0] SEED_RESET = 32'h00000001;
  // Reply class codes from the command interpreter.
  localparam logic [1:0] CMD_OTHER      = 2'h0;
  localparam logic [1:0] CMD_READ_AXIS  = 2'h1;
  localparam logic [1:0] CMD_READ_GLOB  = 2'h2;
  localparam logic [1:0] CMD_READ_IO    = 2'h3;
endpackage : gpar_pkg

//--- hdl/global_param_bank.sv
// Global parameter bank with user variables and interrupt configuration.
`timescale 1ns/1ps
module global_param_bank
  import gpar_pkg::*;
#(
  parameter int NVAR = gpar_pkg::USER_VARS
)(
  // Clock and reset; clock is the millisecond timebase.
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Parameter access port.
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  bank,
  input  wire logic [7:0]  index,
  input  wire logic [31:0] wr_data,
  output logic      [31:0] rd_data,
  output logic             rd_valid,
  // Startup restore from nonvolatile memory.
  input  wire logic        boot_load,
  input  wire logic [7:0]  boot_index,
  input  wire logic [31:0] boot_data,
  output logic             restore_vars,
  // Nonvolatile mirroring of coordinates.
  output logic             coord_persist,
  // Program state from the interpreter.
  input  wire logic [1:0]  run_state,
  input  wire logic        load_mode,
  input  wire logic [31:0] prog_addr,
  output logic             erase_program,
  output logic             protect_read,
  output logic             protect_write,
  // Link address and direction.
  input  wire logic [7:0]  rx_target,
  output logic             addr2_match,
  input  wire logic        dir_internal,
  input  wire logic        dir_from_input,
  output logic             motor_dir,
  // Reply gating.
  input  wire logic        reply_req,
  input  wire logic [1:0]  cmd_class,
  output logic             reply_allow,
  // Interrupt sources (asynchronous pins) and events.
  input  wire logic        stop_left,
  input  wire logic        stop_right,
  input  wire logic [3:0]  gp_in,
  output logic [8:0]       irq_pending,
  output logic [3:0]       irq_winner,
  output logic             irq_any
);
  import gpar_pkg::*;

  // The bank keeps every setting in plain flip-flops so that a read returns
  // the value in the very next cycle, with no arbitration against writes.
  // Only the user variables live in a memory array; they are the one store large
  // enough to deserve memory, and they carry no reset on purpose, because a
  // warm reset of the control logic must not wipe what the host saved there.
  // Stored settings.
  logic [1:0]  program_protection;        // Protection code.
  logic        coordinate_storage_mode;   // Coordinate mirroring enable.
  logic        user_var_restore_inhibit;  // Skip restore at boot.
  logic [7:0]  secondary_target_address;  // Zero means disabled.
  logic        direction_invert;          // Reverse internal motion.
  logic        reply_suppress;            // Volatile only.
  logic [31:0] millisecond_counter;       // Free running tick count.
  logic [31:0] random_value;              // Generator state.
  logic [31:0] interval [3];              // Timer periods in ms.
  logic [31:0] tcount   [3];              // Timer elapsed counts.
  logic [1:0]  edge_sel [6];              // Per input trigger selection.
  logic [31:0] user_var [NVAR];           // User variable bank.
  logic [5:0]  sync1, sync2, prev;        // Input synchroniser and history.
  logic [5:0]  edge_hit;                  // Qualified edges.

  // Every decode compares both the bank and the setting number, so a write
  // aimed at another bank with the same number cannot leak across.
  // Decode a write to one bank.
  function automatic logic hit(input logic [7:0] b, input logic [7:0] i,
                               input logic [7:0] wb, input logic [7:0] wi);
    hit = (b == wb) && (i == wi);
  endfunction : hit

  // The taps give a long sequence for a small cost; the quality suits test
  // patterns and dither, not anything that must resist prediction.
  // One step of a 32-bit Galois shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr

  // Bank 0 settings; protection change may erase the program in the same edge.
  // The erase request is a single-cycle pulse raised in the same edge that
  // takes the new code, so the program store can wipe itself before anyone
  // is able to issue a read under the weakened protection.
  // The reply-suppress flag has no path from the boot restore on purpose:
  // it must always come up cleared, whatever the stored settings hold.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      program_protection       <= 2'h0;
      coordinate_storage_mode  <= 1'b0;
      user_var_restore_inhibit <= 1'b0;
      secondary_target_address <= 8'h00;
      direction_invert         <= 1'b0;
      reply_suppress           <= 1'b0;
      erase_program            <= 1'b0;
    end
    else
    begin
      erase_program <= 1'b0;
      if (wr_en && hit(bank, index, BANK_GLOBAL, GP_PROTECT))
      begin
        // Losing readout protection wipes the program so it cannot be read.
        erase_program <= program_protection[PROT_READ_BIT] & ~wr_data[PROT_READ_BIT];
        program_protection <= wr_data[1:0];
      end
      if (wr_en && hit(bank, index, BANK_GLOBAL, GP_COORD))
        coordinate_storage_mode <= wr_data[0];
      if (wr_en && hit(bank, index, BANK_GLOBAL, GP_NORESTOR))
        user_var_restore_inhibit <= wr_data[0];
      if (wr_en && hit(bank, index, BANK_GLOBAL, GP_ADDR2))
        secondary_target_address <= wr_data[7:0];
      if (wr_en && hit(bank, index, BANK_GLOBAL, GP_DIRINV))
        direction_invert <= wr_data[0];
      if (wr_en && hit(bank, index, BANK_GLOBAL, GP_NOREPLY))
        reply_suppress <= (wr_data == 32'h00000001);
    end
  end

  // Tick counter: counts every clock, a write reloads it.
  // The clock of this block is the millisecond timebase, so one increment per
  // edge is one increment per millisecond.
  // A write wins over the increment in the same edge; the host then reads back
  // exactly its value plus the ticks that have passed since.
  // The counter wraps silently from all ones to zero.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      millisecond_counter <= 32'h00000000;
    else if (wr_en && hit(bank, index, BANK_GLOBAL, GP_TICKS))
      millisecond_counter <= wr_data;
    else
      millisecond_counter <= millisecond_counter + 32'h00000001;
  end

  // Random source: steps on each read, a write seeds it.
  // Stepping only on reads keeps the sequence repeatable after a seed, which
  // makes programs that rely on it testable.
  // The top bit of the returned value is cleared so that the result is never
  // negative when it is handled as a signed number.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      random_value <= SEED_RESET;
    else if (wr_en && hit(bank, index, BANK_GLOBAL, GP_RANDOM))
      // A zero seed would lock the register, so it is forced non-zero.
      random_value <= (wr_data == 32'h0) ? SEED_RESET : wr_data;
    else if (rd_en && hit(bank, index, BANK_GLOBAL, GP_RANDOM))
      random_value <= lfsr(random_value);
  end

  // User variables; boot restore only reaches the persistent part.
  // A host write takes precedence over a restore in the same cycle, since the
  // newer value must not be overwritten by an older saved copy.
  // Restores are dropped entirely while the inhibit setting is set, and any
  // restore aimed above the persistent range is ignored.
  always_ff @(posedge clk_sys)
  begin
    if (wr_en && bank == BANK_USER && 32'(index) < NVAR)
      user_var[index] <= wr_data;
    else if (boot_load && restore_vars && 32'(boot_index) < USER_PERSIST)
      user_var[boot_index] <= boot_data;
  end

  // Interrupt configuration writes through bank 3.
  // Timer periods and trigger selections both come up at zero, so no timer
  // and no input can raise an event until software has chosen to allow it.
  // Setting numbers that do not name an interrupt setting are ignored here,
  // and the same numbers read back as zero.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int k = 0; k < 3; k++)
        interval[k] <= 32'h00000000;
      for (int k = 0; k < 6; k++)
        edge_sel[k] <= EDGE_OFF;
    end
    else if (wr_en && bank == BANK_IRQ)
    begin
      if (index <= IP_TIMER2)
        interval[index[1:0]] <= wr_data;
      else if (index == IP_STOPL)
        edge_sel[0] <= wr_data[1:0];
      else if (index == IP_STOPR)
        edge_sel[1] <= wr_data[1:0];
      else if (index >= IP_IN0 && index <= IP_IN3)
        edge_sel[3'(index - IP_IN0) + 3'h2] <= wr_data[1:0];
    end
  end

  // Periodic timers; a zero period never fires.
  // Each timer counts from zero up to one below its period and then restarts,
  // so events are spaced by exactly the period in ticks.
  // The comparison is greater-or-equal so that shortening the period while a
  // count is running cannot strand the counter above the new limit for the
  // long time that a wrap of the full 32-bit range would take.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      for (int k = 0; k < 3; k++)
        tcount[k] <= 32'h00000000;
    else
      for (int k = 0; k < 3; k++)
        if (interval[k] == 32'h0 || tcount[k] + 32'h1 >= interval[k])
          tcount[k] <= 32'h00000000;
        else
          tcount[k] <= tcount[k] + 32'h00000001;
  end

  // Two-stage synchroniser, then one sample of history per tick.
  // The switch and input pins are not related to this clock, so only the
  // second stage is ever read by logic; the first may still be settling.
  // A pin that rests high shows one rising step after reset, which is harmless
  // because every trigger selection also resets to off.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      prev  <= 6'h00;
    end
    else
    begin
      sync1 <= {gp_in, stop_right, stop_left};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // Edge qualification by trigger selection.
  // Bit 0 of a selection enables rising edges and bit 1 falling edges, so the
  // code for both is simply the two enables together.
  // Comparing against the previous sample makes each transition count once.
  always_comb
  begin
    for (int k = 0; k < 6; k++)
      edge_hit[k] = (edge_sel[k][0] & sync2[k] & ~prev[k])
                  | (edge_sel[k][1] & ~sync2[k] & prev[k]);
  end

  // Pending events, one pulse each; interrupt number order 0..8.
  // Numbers 0 to 2 are the timers, 3 and 4 the left and right stop switches,
  // and 5 to 8 the general inputs 0 to 3.
  // The events are single-cycle pulses; whoever services them must latch them,
  // as this block keeps no sticky pending state of its own.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      irq_pending <= 9'h000;
    else
    begin
      for (int k = 0; k < 3; k++)
        irq_pending[k] <= (interval[k] != 32'h0) &&
                          (tcount[k] + 32'h1 >= interval[k]);
      irq_pending[8:3] <= edge_hit;
    end
  end

  // Fixed priority: lowest number wins.
  // The loop walks downwards so that the last match, the lowest number, stays.
  // With nothing pending the winner reads as all ones.
  always_comb
  begin
    irq_winner = 4'hf;
    for (int k = NUM_IRQ - 1; k >= 0; k--)
      if (irq_pending[k])
        irq_winner = 4'(k);
  end
  assign irq_any = |irq_pending;

  // Read path, one cycle latency.
  // The data is registered so that the host sees a clean word for one cycle,
  // qualified by the valid pulse; it returns to zero in the cycle after.
  // Unmapped numbers and banks read as zero rather than as stale data.
  // Reading the random value also steps the generator in the same edge.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data  <= 32'h00000000;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      rd_data  <= 32'h00000000;
      if (rd_en && bank == BANK_USER && 32'(index) < NVAR)
        rd_data <= user_var[index];
      else if (rd_en && bank == BANK_IRQ)
      begin
        if (index <= IP_TIMER2)
          rd_data <= interval[index[1:0]];
        else if (index == IP_STOPL)
          rd_data <= {30'h0, edge_sel[0]};
        else if (index == IP_STOPR)
          rd_data <= {30'h0, edge_sel[1]};
        else if (index >= IP_IN0 && index <= IP_IN3)
          rd_data <= {30'h0, edge_sel[3'(index - IP_IN0) + 3'h2]};
      end
      else if (rd_en && bank == BANK_GLOBAL)
        unique case (index)
          GP_PROTECT:  rd_data <= {30'h0, program_protection};
          GP_COORD:    rd_data <= {31'h0, coordinate_storage_mode};
          GP_NORESTOR: rd_data <= {31'h0, user_var_restore_inhibit};
          GP_ADDR2:    rd_data <= {24'h0, secondary_target_address};
          GP_DIRINV:   rd_data <= {31'h0, direction_invert};
          GP_RUNSTATE: rd_data <= {30'h0, run_state};
          GP_LOADMODE: rd_data <= {31'h0, load_mode};
          GP_PROGPOS:  rd_data <= prog_addr;
          GP_TICKS:    rd_data <= millisecond_counter;
          GP_RANDOM:   rd_data <= {1'b0, random_value[30:0]};
          GP_NOREPLY:  rd_data <= {31'h0, reply_suppress};
          default:     rd_data <= 32'h00000000;
        endcase
    end
  end

  // Derived control outputs.
  // These are plain decodes of the stored settings, so they follow a write
  // in the same edge that takes it.
  assign protect_read  = program_protection[PROT_READ_BIT];
  assign protect_write = program_protection[PROT_WRITE_BIT];
  assign coord_persist = coordinate_storage_mode;
  assign restore_vars  = ~user_var_restore_inhibit;
  // Zero means the secondary address is switched off.
  assign addr2_match   = (secondary_target_address != 8'h00) &&
                         (rx_target == secondary_target_address);
  // Step/direction input motion is never inverted.
  assign motor_dir     = dir_internal ? (dir_from_input ^ direction_invert)
                                      : dir_from_input;
  // Read commands still get answers while replies are suppressed.
  assign reply_allow   = reply_req & (~reply_suppress | (cmd_class != CMD_OTHER));

endmodule : global_param_bank

//--- tb/global_param_bank_properties.sv
// Checker of port relations of the global parameter bank.
`timescale 1ns/1ps
module global_param_bank_properties
  import gpar_pkg::*;
(
  // Clock, reset and parameter access.
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  bank,
  input wire logic [7:0]  index,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] rd_data,
  input wire logic        rd_valid,
  // Program state, link address and direction.
  input wire logic [31:0] prog_addr,
  input wire logic        erase_program,
  input wire logic [7:0]  rx_target,
  input wire logic        addr2_match,
  input wire logic        dir_internal,
  input wire logic        dir_from_input,
  input wire logic        motor_dir,
  // Reply gating and events.
  input wire logic        reply_req,
  input wire logic [1:0]  cmd_class,
  input wire logic        reply_allow,
  input wire logic [8:0]  irq_pending,
  input wire logic [3:0]  irq_winner
);
  // All relations live in the one clock domain.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  prog_read_a:
    assert property (rd_en && bank == BANK_GLOBAL && index == GP_PROGPOS |=>
      rd_valid && rd_data == $past(prog_addr)) else $error("program position read wrong");
  // The load is checked through a read two edges later, so one tick has passed.
  tick_load_a:
    assert property (wr_en && bank == BANK_GLOBAL && index == GP_TICKS ##1 !wr_en ##1 !wr_en &&
      rd_en && bank == BANK_GLOBAL && index == GP_TICKS |=> rd_data == $past(wr_data, 3) + 32'h1)
      else $error("tick counter did not continue from loaded value");
  random_range_a:
    assert property (rd_en && bank == BANK_GLOBAL && index == GP_RANDOM |=>
      rd_valid && !rd_data[31]) else $error("random value out of range");
  erase_cause_a:
    assert property (erase_program |-> $past(wr_en && bank == BANK_GLOBAL &&
      index == GP_PROTECT) ##1 !erase_program) else $error("erase pulse without cause");
  read_reply_a:
    assert property (reply_req && cmd_class != CMD_OTHER |-> reply_allow)
      else $error("read command reply blocked");
  addr_zero_a:
    assert property (addr2_match |-> rx_target != 8'h00) else $error("address zero matched");
  dir_external_a:
    assert property (!dir_internal |-> motor_dir == dir_from_input)
      else $error("step input direction altered");
  irq_priority_a:
    assert property (irq_pending != 9'h000 |-> irq_pending[irq_winner] &&
      (irq_pending & ((9'h001 << irq_winner) - 9'h001)) == 9'h000) else $error("wrong winner");
  irq_idle_a:
    assert property (irq_pending == 9'h000 |-> irq_winner == 4'hf) else $error("idle winner");
  edge_single_a:
    assert property (irq_pending[5] |=> !irq_pending[5]) else $error("input event repeated");
endmodule : global_param_bank_properties

bind global_param_bank global_param_bank_properties i_global_param_bank_properties (.*);

//--- tb/testbench.sv
// Self-checking bench for the global parameter bank.
`timescale 1ns/1ps
module testbench;
  import gpar_pkg::*;
  typedef struct {logic [7:0] b; logic [7:0] i; logic [31:0] w; logic [31:0] e;} row_t;
  localparam logic [31:0] PA = 32'h0000_1234;  // Program address shown by the interpreter.
  logic        clk_sys, resetn, wr_en, rd_en, boot_load, load_mode, dir_internal;
  logic        dir_from_input, reply_req, stop_left, stop_right, m0;
  logic        rd_valid, restore_vars, coord_persist, erase_program, protect_read;
  logic        protect_write, addr2_match, motor_dir, reply_allow, irq_any;
  logic [1:0]  run_state, cmd_class;
  logic [3:0]  gp_in, irq_winner;
  logic [7:0]  bank, index, boot_index, rx_target;
  logic [8:0]  irq_pending;
  logic [31:0] wr_data, rd_data, boot_data, prog_addr, d, r1;
  int          fail_count, n_tests, any_n, ev[9];
  // Write, then read back; read-only and unmapped places keep their own value.
  row_t rows [10] = '{'{8'h00, GP_COORD, 32'h1, 32'h1}, '{8'h00, GP_ADDR2, 32'h2a, 32'h2a},
    '{8'h00, GP_DIRINV, 32'h1, 32'h1}, '{8'h00, GP_PROGPOS, 32'h5, PA},
    '{8'h00, GP_RUNSTATE, 32'h1, 32'h2}, '{8'h00, GP_LOADMODE, 32'h0, 32'h1},
    '{8'h00, 8'h60, 32'h7, 32'h0}, '{8'h05, 8'h00, 32'h3, 32'h0},
    '{BANK_IRQ, IP_STOPR, 32'h2, 32'h2}, '{BANK_USER, 8'hff, 32'hffff_fffb, 32'hffff_fffb}};
  int prot [5] = '{3, 2, 1, 0, 2};  // Protection sequence.
  int ers [5] = '{0, 1, 0, 1, 0};   // Erase expected after each step.

  global_param_bank i_global_param_bank (.*);

  // Clock of 4 ns.
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Count event pulses of every interrupt source.
  always @(posedge clk_sys)
  begin
    for (int k = 0; k < 9; k++) if (irq_pending[k] === 1'b1) ev[k]++;
    if (irq_any === 1'b1) any_n++;
  end

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      $display("CHECK FAILED at %0t: %s", $time, m);
      fail_count++;
    end
  endtask : chk
  // Each access starts at a fresh falling edge, so strobes never change twice in one step.
  task automatic wr(input logic [7:0] b, input logic [7:0] i, input logic [31:0] v);
    @(negedge clk_sys);
    {bank, index, wr_data, wr_en} = {b, i, v, 1'b1};
    @(negedge clk_sys) wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] b, input logic [7:0] i, output logic [31:0] v);
    @(negedge clk_sys);
    {bank, index, rd_en} = {b, i, 1'b1};
    @(negedge clk_sys) rd_en = 1'b0;
    chk(rd_valid, "no read answer");
    v = rd_data;
  endtask : rd
  // Toggle the selected pins and give the synchroniser time to settle.
  task automatic tog(input logic [5:0] m);
    {stop_left, stop_right, gp_in} = {stop_left, stop_right, gp_in} ^ m;
    repeat (8) @(negedge clk_sys);
  endtask : tog
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Watchdog, far beyond the few hundred cycles that the tests need.
  initial
  begin
    #200000;
    fail_count++;
    finish_test();
  end

  initial
  begin
    {wr_en, rd_en, boot_load, reply_req, stop_left, stop_right, dir_internal} = '0;
    {dir_from_input, bank, index, boot_index, rx_target, wr_data, boot_data} = '0;
    {gp_in, cmd_class, run_state, load_mode, prog_addr} = {6'h0, 2'h2, 1'b1, PA};
    resetn = 1'b0;
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    chk(restore_vars === 1'b1 && irq_pending === 9'h000, "reset outputs");
    chk(irq_any === 1'b0, "event seen after reset");
    foreach (rows[k])
    begin
      wr(rows[k].b, rows[k].i, rows[k].w);
      rd(rows[k].b, rows[k].i, d);
      chk(d === rows[k].e, "read back mismatch");
    end
    chk(coord_persist === 1'b1, "coordinate mirroring off");
    rx_target = 8'h2a;
    dir_internal = 1'b1;
    #1 chk(addr2_match === 1'b1, "secondary address missed");
    m0 = motor_dir;
    wr(BANK_GLOBAL, GP_DIRINV, 32'h0);
    chk(motor_dir === ~m0, "invert ignored in internal mode");
    dir_internal = 1'b0;
    dir_from_input = 1'b1;
    wr(BANK_GLOBAL, GP_DIRINV, 32'h1);
    wr(BANK_GLOBAL, GP_ADDR2, 32'h0);
    rx_target = 8'h00;
    #1 chk(addr2_match === 1'b0 && motor_dir === 1'b1, "zero address or direction");
    $display("test registers finished");
    foreach (prot[k])
    begin
      wr(BANK_GLOBAL, GP_PROTECT, prot[k]);
      chk(erase_program === ers[k][0], "erase pulse");
      chk({protect_write, protect_read} === prot[k][1:0], "protection bits");
    end
    wr(BANK_GLOBAL, GP_TICKS, 32'hffff_fffe);
    rd(BANK_GLOBAL, GP_TICKS, d);
    chk(d === 32'hffff_ffff, "tick load");
    rd(BANK_GLOBAL, GP_TICKS, d);
    chk(d === 32'h0000_0001, "tick wrap");
    wr(BANK_GLOBAL, GP_RANDOM, 32'h4d);
    rd(BANK_GLOBAL, GP_RANDOM, r1);
    rd(BANK_GLOBAL, GP_RANDOM, d);
    chk(d !== r1 && r1[31] === 1'b0, "random repeats");
    wr(BANK_GLOBAL, GP_RANDOM, 32'h4d);
    rd(BANK_GLOBAL, GP_RANDOM, d);
    chk(d === r1, "seed not reloaded");
    wr(BANK_GLOBAL, GP_NOREPLY, 32'h1);
    reply_req = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      cmd_class = c[1:0];
      #1 chk(reply_allow === (c != 0), "reply gating");
    end
    $display("test protection, ticks, random, replies finished");
    @(negedge clk_sys);
    boot_index = 8'h03;
    boot_data = 32'h55aa;
    boot_load = 1'b1;
    @(negedge clk_sys) boot_load = 1'b0;
    rd(BANK_USER, 8'h03, d);
    chk(d === 32'h55aa, "boot restore");
    wr(BANK_GLOBAL, GP_NORESTOR, 32'h1);
    wr(BANK_USER, 8'h04, 32'h7);
    {boot_index, boot_load} = {8'h04, 1'b1};
    @(negedge clk_sys) boot_load = 1'b0;
    rd(BANK_USER, 8'h04, d);
    chk(d === 32'h7 && restore_vars === 1'b0, "inhibited restore");
    wr(BANK_IRQ, IP_TIMER0, 32'h3);
    wr(BANK_IRQ, 8'h01, 32'h5);
    repeat (10) @(negedge clk_sys);
    ev = '{default: 0};
    any_n = 0;
    repeat (30) @(negedge clk_sys);
    chk(ev[0] == 10 && ev[1] == 6, "timer periods");
    // Periods 3 and 5 coincide once in every 15 cycles, so 10 + 6 - 2 cycles.
    chk(any_n == 14, "combined event count");
    chk(ev[2] == 0, "zero period fired");
    for (int c = 0; c < 4; c++)
    begin
      for (int s = 0; s < 6; s++) wr(BANK_IRQ, 8'((s < 2) ? IP_STOPL + s : IP_IN0 + s - 2), c);
      ev = '{default: 0};
      tog(6'h3f);
      tog(6'h3f);
      for (int s = 3; s < 9; s++) chk(ev[s] == c[0] + c[1], "edge events");
    end
    $display("test restore, timers, edges finished");
    cmd_class = CMD_OTHER;  // Only a plain command shows whether replies are held back.
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    rd(BANK_GLOBAL, GP_NOREPLY, d);
    chk(d === 32'h0 && reply_allow === 1'b1, "suppress kept over reset");
    $display("test second reset finished");
    finish_test();
  end
endmodule : testbench
